/* mon_regs_consts.svh */
`ifndef MON_REGS_CONSTS_SVH
`define MON_REGS_CONSTS_SVH
// Printed offsets are indices; byte address is four times the index
`define IDX_TRIGGER 8'h1C
`define IDX_SWRESET 8'h1D
`define IDX_ALARM 8'h1E
`define IDX_CONFIG 8'h20
`define IDX_ALARM_EN 8'h21
`define IDX_LIMITS 8'h22
`define IDX_IRQ_STATUS 8'h23
`define IDX_IRQ_MASK 8'h24
`define IDX_CONV_STATUS 8'h25
`define BIT_OUT_LOAD 1
`define BIT_CONV_START 0
`define BIT_SRC_SELECT 13
`define BIT_READY 14
`define RESET_KEY 4'hC
`define ALARM_RESERVED_MASK 16'hF7FF
`define RESET_VALUE_16 16'h0000
`define LIMIT_A_LSB 0
`define LIMIT_B_LSB 16
`define CONV_TIME_NS 2000
`define CLK_PERIOD_NS 100
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IRQ_BIT_SWRESET 2
`define IRQ_BIT_CONV_DONE 1
`define IRQ_BIT_ALARM 0
`endif

/* mon_regs_pkg.sv */
package mon_regs_pkg;
   typedef struct packed {
      logic [11:0] out4;
      logic [11:0] out3;
      logic [11:0] out2;
      logic [11:0] out1;
   } out_codes_t;

   typedef struct packed {
      logic [3:0] intOver;
      logic [3:0] csOver;
      logic negSupplyBad;
      logic remote2Hi;
      logic remote2Lo;
      logic remote1Hi;
      logic remote1Lo;
      logic localHi;
      logic localLo;
      logic remote2En;
      logic remote1En;
      logic localEn;
   } sense_in_t;

   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_RUN
   } conv_state_t;
endpackage

/* limit_compare.sv */
`timescale 1ns/1ps
module limit_compare (
   input wire logic clk, // Clock
   input wire logic arst_n, // Async reset, active low
   input wire logic [11:0] code, // Output converter code
   input wire logic [11:0] limit, // Upper limit
   output logic over // Code above limit, registered
);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         over <= 1'b0;
      end else begin
         over <= code > limit;
      end
   end
endmodule

/* conv_sequencer.sv */
`timescale 1ns/1ps
`include "mon_regs_consts.svh"
module conv_sequencer (
   input wire logic clk, // Clock
   input wire logic arst_n, // Async reset, active low
   input wire logic softRst, // Device soft reset pulse
   input wire logic startReq, // Start request pulse
   input wire logic enabled, // Converter powered and set up
   output logic ready, // Ready to be triggered
   output logic started, // Pulse when conversion begins
   output logic done // Pulse when conversion ends
);
   mon_regs_pkg::conv_state_t state;
   logic [15:0] count;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= mon_regs_pkg::CONV_IDLE;
         count <= 16'h0000;
         started <= 1'b0;
         done <= 1'b0;
      end else begin
         started <= 1'b0;
         done <= 1'b0;
         if (softRst) begin
            state <= mon_regs_pkg::CONV_IDLE;
            count <= 16'h0000;
         end else begin
            unique case (state)
               mon_regs_pkg::CONV_IDLE: begin
                  if (startReq && ready) begin // R05
                     state <= mon_regs_pkg::CONV_RUN;
                     count <= 16'(`CONV_CYCLES - 1);
                     started <= 1'b1;
                  end
               end
               mon_regs_pkg::CONV_RUN: begin
                  if (count == 16'h0000) begin
                     state <= mon_regs_pkg::CONV_IDLE;
                     done <= 1'b1;
                  end else begin
                     count <= count - 16'h0001;
                  end
               end
            endcase
         end
      end
   end

   // Ready drops while running, returns once stopped
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ready <= 1'b0;
      end else begin
         ready <= enabled && !softRst && (state == mon_regs_pkg::CONV_IDLE) && !(startReq && ready); // R18
      end
   end
endmodule

/* monitor_trigger_reset_alarm_regs.sv */
`timescale 1ns/1ps
`include "mon_regs_consts.svh"
// Operation
// R01 - Trigger bit 1 loads synchronous outputs together
// R02 - Load strobe self-clears after data update
// R03 - Trigger bit 0 starts a conversion
// R04 - Start strobe self-clears once conversion begins
// R05 - Start ignored unless converter is ready
// R06 - Key 1100 resets device; else nothing
// R07 - Bits 15/14: outputs 4/3 over limit
// R08 - Bits 13/12: outputs 2/1 over limit
// R09 - Bit 10 negative supply; bit 11 zero
// R10 - Bits 9/8: remote 2 high/low
// R11 - Bits 7/6: remote 1 high/low
// R12 - Remote alarms zero while sensor disabled
// R13 - Bits 5/4: local sensor high/low
// R14 - Local alarms zero while sensor disabled
// R15 - Bits 3..0: channel range alarms
// R16 - Select bit picks internal or current-sense
// R17 - Alarm pin only from enabled alarms
// R18 - Ready flag low while converting
// R19 - Software writes zero to reserved bits
module monitor_trigger_reset_alarm_regs (
   input wire logic clk, // Clock, 10 MHz
   input wire logic arst_n, // Async reset, active low
   input wire logic [31:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [31:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire mon_regs_pkg::out_codes_t outCodes, // Output converter codes
   input wire mon_regs_pkg::sense_in_t senseIn, // Sensor comparator inputs
   input wire logic convEnabled, // Sampling converter set up
   output logic syncOutputLoad, // Pulse: load sync outputs
   output logic convStartPulse, // Pulse: conversion begun
   output logic deviceSoftReset, // Pulse: whole-device reset
   output logic alarmOutputPin, // Alarm output, active high
   output logic irq // Interrupt, level
);
   logic awHeld;
   logic wHeld;
   logic [7:0] awIdx;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic doWrite;
   logic [7:0] arIdx;
   logic [15:0] configReg;
   logic [15:0] alarmEnReg;
   logic [31:0] limitsReg;
   logic [15:0] irqStatusReg;
   logic [15:0] irqMaskReg;
   logic [1:0] triggerReg;
   logic loadPending;
   logic startPending;
   logic [15:0] alarmFlags;
   logic [15:0] alarmPrev;
   logic [3:0] outOver;
   logic [3:0] chanRange;
   logic convReady;
   logic convStarted;
   logic convDone;
   logic softRst;
   logic [15:0] irqSet;
   logic [15:0] irqClr;
   logic [15:0] rdValue;
   logic rdHit;
   logic wrHit;

   // AXI write channel: address and data taken in either order
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awIdx <= 8'h00;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         s_axi_awready <= !awHeld && !s_axi_awready && !s_axi_awvalid ? 1'b1 : (!awHeld && !s_axi_awready);
         s_axi_wready <= !wHeld && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awIdx <= s_axi_awaddr[9:2];
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
         end
      end
   end

   always_comb begin
      unique case (awIdx)
         `IDX_TRIGGER, `IDX_SWRESET, `IDX_CONFIG, `IDX_ALARM_EN, `IDX_LIMITS, `IDX_IRQ_STATUS,
         `IDX_IRQ_MASK: wrHit = 1'b1;
         default: wrHit = 1'b0;
      endcase
   end

   // Read channel
   assign arIdx = s_axi_araddr[9:2];

   always_comb begin
      rdHit = 1'b1;
      unique case (arIdx)
         `IDX_TRIGGER: rdValue = `RESET_VALUE_16;
         `IDX_SWRESET: rdValue = `RESET_VALUE_16;
         `IDX_ALARM: rdValue = alarmFlags & `ALARM_RESERVED_MASK; // R09
         `IDX_CONFIG: rdValue = configReg;
         `IDX_ALARM_EN: rdValue = alarmEnReg;
         `IDX_LIMITS: rdValue = limitsReg[15:0];
         `IDX_IRQ_STATUS: rdValue = irqStatusReg;
         `IDX_IRQ_MASK: rdValue = irqMaskReg;
         `IDX_CONV_STATUS: rdValue = {1'b0, convReady, 14'h0000} | {14'h0000, loadPending, startPending};
         default: begin
            rdValue = 16'h0000;
            rdHit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rdValue};
            s_axi_rresp <= rdHit ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Software reset key, only low byte lane matters
   assign softRst = doWrite && awIdx == `IDX_SWRESET && wStrb[0] && wData[3:0] == `RESET_KEY; // R06

   // Configuration registers; returned to defaults by the soft reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         configReg <= `RESET_VALUE_16;
         alarmEnReg <= `RESET_VALUE_16;
         limitsReg <= 32'h0000_0000;
         irqMaskReg <= `RESET_VALUE_16;
      end else if (softRst) begin
         configReg <= `RESET_VALUE_16;
         alarmEnReg <= `RESET_VALUE_16;
         limitsReg <= 32'h0000_0000;
         irqMaskReg <= `RESET_VALUE_16;
      end else if (doWrite) begin
         for (int b = 0; b < 4; b++) begin
            if (wStrb[b] && awIdx == `IDX_LIMITS) begin
               limitsReg[b*8 +: 8] <= wData[b*8 +: 8];
            end
         end
         for (int b = 0; b < 2; b++) begin
            if (wStrb[b]) begin
               if (awIdx == `IDX_CONFIG) begin
                  configReg[b*8 +: 8] <= wData[b*8 +: 8];
               end
               if (awIdx == `IDX_ALARM_EN) begin
                  alarmEnReg[b*8 +: 8] <= wData[b*8 +: 8];
               end
               if (awIdx == `IDX_IRQ_MASK) begin
                  irqMaskReg[b*8 +: 8] <= wData[b*8 +: 8];
               end
            end
         end
      end
   end

   // Trigger strobes: write-only, reserved bits dropped
   assign triggerReg = (doWrite && awIdx == `IDX_TRIGGER && wStrb[0]) ? wData[1:0] : 2'b00;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         loadPending <= 1'b0;
         syncOutputLoad <= 1'b0;
      end else begin
         syncOutputLoad <= triggerReg[`BIT_OUT_LOAD] && !softRst; // R01
         loadPending <= triggerReg[`BIT_OUT_LOAD] && !softRst; // R02
      end
   end

   // Start request lives one cycle; a busy converter drops it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         startPending <= 1'b0;
         convStartPulse <= 1'b0;
         deviceSoftReset <= 1'b0;
      end else begin
         startPending <= triggerReg[`BIT_CONV_START] && !softRst; // R03
         convStartPulse <= convStarted; // R04
         deviceSoftReset <= softRst; // R06
      end
   end

   conv_sequencer convSeq (
      .clk(clk),
      .arst_n(arst_n),
      .softRst(softRst),
      .startReq(startPending),
      .enabled(convEnabled),
      .ready(convReady),
      .started(convStarted),
      .done(convDone)
   );

   // Output limit comparators
   limit_compare cmp1 (.clk(clk), .arst_n(arst_n), .code(outCodes.out1),
      .limit(limitsReg[`LIMIT_A_LSB +: 12]), .over(outOver[0]));
   limit_compare cmp2 (.clk(clk), .arst_n(arst_n), .code(outCodes.out2),
      .limit(limitsReg[`LIMIT_A_LSB +: 12]), .over(outOver[1]));
   limit_compare cmp3 (.clk(clk), .arst_n(arst_n), .code(outCodes.out3),
      .limit(limitsReg[`LIMIT_B_LSB +: 12]), .over(outOver[2]));
   limit_compare cmp4 (.clk(clk), .arst_n(arst_n), .code(outCodes.out4),
      .limit(limitsReg[`LIMIT_B_LSB +: 12]), .over(outOver[3]));

   assign chanRange = configReg[`BIT_SRC_SELECT] ? senseIn.csOver : senseIn.intOver; // R16

   // Alarm status, live view of conditions
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         alarmFlags <= `RESET_VALUE_16;
      end else begin
         alarmFlags[15:14] <= {outOver[3], outOver[2]}; // R07
         alarmFlags[13:12] <= {outOver[1], outOver[0]}; // R08
         alarmFlags[11] <= 1'b0; // R09
         alarmFlags[10] <= senseIn.negSupplyBad; // R09
         alarmFlags[9:8] <= senseIn.remote2En ? {senseIn.remote2Hi, senseIn.remote2Lo} : 2'b00; // R10 R12
         alarmFlags[7:6] <= senseIn.remote1En ? {senseIn.remote1Hi, senseIn.remote1Lo} : 2'b00; // R11 R12
         alarmFlags[5:4] <= senseIn.localEn ? {senseIn.localHi, senseIn.localLo} : 2'b00; // R13 R14
         alarmFlags[3:0] <= chanRange; // R15
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         alarmOutputPin <= 1'b0;
         alarmPrev <= `RESET_VALUE_16;
      end else begin
         alarmOutputPin <= |(alarmFlags & alarmEnReg & `ALARM_RESERVED_MASK); // R17
         alarmPrev <= alarmFlags;
      end
   end

   // Sticky interrupt status; a set in the clearing cycle wins
   always_comb begin
      irqSet = 16'h0000;
      irqSet[`IRQ_BIT_ALARM] = |(alarmFlags & ~alarmPrev);
      irqSet[`IRQ_BIT_CONV_DONE] = convDone;
      irqSet[`IRQ_BIT_SWRESET] = softRst;
      irqClr = 16'h0000;
      if (doWrite && awIdx == `IDX_IRQ_STATUS) begin
         irqClr = wData[15:0] & {{8{wStrb[1]}}, {8{wStrb[0]}}};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irqStatusReg <= `RESET_VALUE_16;
         irq <= 1'b0;
      end else begin
         irqStatusReg <= (irqStatusReg & ~irqClr) | irqSet;
         irq <= |(irqStatusReg & irqMaskReg);
      end
   end
endmodule

/* mon_regs_chk.sv */
`timescale 1ns/1ps
module mon_regs_chk (
   input wire logic clk, // Clock
   input wire logic arst_n, // Async reset, active low
   input wire logic s_axi_arvalid, // Read address valid
   input wire logic s_axi_arready, // Read address ready
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [1:0] s_axi_bresp, // Write response
   input wire logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire mon_regs_pkg::out_codes_t outCodes, // Output converter codes
   input wire mon_regs_pkg::sense_in_t senseIn, // Sensor inputs
   input wire logic convEnabled, // Converter set up
   input wire logic syncOutputLoad, // Load pulse
   input wire logic convStartPulse, // Conversion begun
   input wire logic deviceSoftReset, // Soft reset pulse
   input wire logic alarmOutputPin // Alarm pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Five cycles cover the alarm bit, compare and pin stages
   sequence quiet_s;
      (senseIn[$bits(senseIn)-1:3] == '0 && outCodes == '0) [*5];
   endsequence
   sequence idle_s;
      !convEnabled [*6];
   endsequence
   a_load_one_pulse: assert property (syncOutputLoad |=> !syncOutputLoad) else $error("load pulse too long");
   a_start_no_repeat: assert property (convStartPulse |=> !convStartPulse [*8]) else $error("start repeated");
   a_reset_one_pulse: assert property (deviceSoftReset |=> !deviceSoftReset) else $error("reset pulse too long");
   a_pin_quiet: assert property (quiet_s |-> !alarmOutputPin) else $error("pin high without alarm");
   a_start_needs_ready: assert property (idle_s |-> !convStartPulse) else $error("start while not ready");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
endmodule
bind monitor_trigger_reset_alarm_regs mon_regs_chk u_mon_regs_chk (.clk, .arst_n, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .outCodes, .senseIn,
   .convEnabled, .syncOutputLoad, .convStartPulse, .deviceSoftReset, .alarmOutputPin);

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000, s_axi_araddr = 32'h0000_0000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd, r;
   logic [31:0] seed = 32'h1595_b796;
   mon_regs_pkg::out_codes_t outCodes = '0, oc;
   mon_regs_pkg::sense_in_t senseIn = '0, si;
   logic convEnabled = 1'b0;
   logic syncOutputLoad, convStartPulse, deviceSoftReset, alarmOutputPin, irq;
   logic [11:0] la, lb;
   int n_mismatch = 0, n_tests = 0, nLoad = 0, nStart = 0, nRst = 0, k;
   always #50 clk = ~clk;
   monitor_trigger_reset_alarm_regs u_monitor_trigger_reset_alarm_regs (.clk, .arst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .outCodes, .senseIn, .convEnabled, .syncOutputLoad, .convStartPulse,
      .deviceSoftReset, .alarmOutputPin, .irq);
   always @(posedge clk) begin
      if (syncOutputLoad === 1'b1) nLoad <= nLoad + 1;
      if (convStartPulse === 1'b1) nStart <= nStart + 1;
      if (deviceSoftReset === 1'b1) nRst <= nRst + 1;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [15:0] expAlarm(mon_regs_pkg::out_codes_t o, mon_regs_pkg::sense_in_t s,
         logic [11:0] a, logic [11:0] b, logic sel);
      return {o.out4 > b, o.out3 > b, o.out2 > a, o.out1 > a, 1'b0, s.negSupplyBad,
         s.remote2Hi & s.remote2En, s.remote2Lo & s.remote2En, s.remote1Hi & s.remote1En,
         s.remote1Lo & s.remote1En, s.localHi & s.localEn, s.localLo & s.localEn, sel ? s.csOver : s.intOver};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Response ready goes up with the request, so the answer is taken at the first edge it shows
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= 32'(idx) << 2;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         resp = s_axi_bresp;
      end while (!s_axi_bvalid && n < 100);
      s_axi_bready <= 1'b0;
      if (n >= 100) n_mismatch++;
   endtask
   task automatic rdr(input logic [7:0] idx);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= 32'(idx) << 2;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         rd = s_axi_rdata;
         resp = s_axi_rresp;
      end while (!s_axi_rvalid && n < 100);
      s_axi_rready <= 1'b0;
      if (n >= 100) n_mismatch++;
   endtask
   task automatic finish_test();
      $display("TB: tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #(20000 * 100);
      n_mismatch++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      cyc(2);
      rdr(8'h1C);
      chk(rd, 32'h0000_0000);
      rdr(8'h1D);
      chk(rd, 32'h0000_0000);
      rdr(8'h1E);
      chk(rd, 32'h0000_0000);
      rdr(8'h3F);
      chk(32'(resp), 32'h0000_0002);
      wr(8'h3F, 32'h0000_0000);
      chk(32'(resp), 32'h0000_0002);
      $display("TB: reset values done");
      // First pass puts codes exactly on and one above the limit
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         la = r[11:0];
         lb = (i == 0) ? la : r[27:16];
         oc = (i == 0) ? {la + 12'h001, la, la + 12'h001, la} : 48'({rnd(), rnd()});
         r = rnd();
         si = r[$bits(si)-1:0];
         wr(8'h20, 32'(i[0]) << 13);
         wr(8'h22, {4'h0, lb, 4'h0, la});
         outCodes <= oc;
         senseIn <= si;
         cyc(5);
         rdr(8'h1E);
         chk(rd, {16'h0000, expAlarm(oc, si, la, lb, i[0])});
      end
      $display("TB: alarm map done");
      outCodes <= '0;
      senseIn <= '0;
      wr(8'h21, 32'h0000_0400);
      wr(8'h24, 32'h0000_0001);
      senseIn.remote1En <= 1'b1;
      senseIn.remote1Hi <= 1'b1;
      cyc(5);
      chk(32'(alarmOutputPin), 32'h0000_0000);
      wr(8'h23, 32'h0000_0007);
      cyc(3);
      chk(32'(irq), 32'h0000_0000);
      senseIn.negSupplyBad <= 1'b1;
      cyc(5);
      chk(32'(alarmOutputPin), 32'h0000_0001);
      chk(32'(irq), 32'h0000_0001);
      wr(8'h24, 32'h0000_0000);
      cyc(3);
      chk(32'(irq), 32'h0000_0000);
      rdr(8'h23);
      chk(32'(rd[0]), 32'h0000_0001);
      wr(8'h23, 32'h0000_0001);
      rdr(8'h23);
      chk(32'(rd[0]), 32'h0000_0000);
      $display("TB: alarm pin and interrupt done");
      k = nLoad;
      wr(8'h1C, 32'h0000_0002);
      chk(32'(resp), 32'h0000_0000);
      cyc(4);
      chk(32'(nLoad - k), 32'h0000_0001);
      convEnabled <= 1'b1;
      cyc(3);
      k = nStart;
      wr(8'h1C, 32'h0000_0001);
      wr(8'h1C, 32'h0000_0001);
      cyc(4);
      rdr(8'h25);
      chk(32'(rd[14]), 32'h0000_0000);
      chk(32'(nStart - k), 32'h0000_0001);
      cyc(30);
      rdr(8'h25);
      chk(32'(rd[14]), 32'h0000_0001);
      rdr(8'h23);
      chk(32'(rd[1]), 32'h0000_0001);
      convEnabled <= 1'b0;
      cyc(3);
      k = nStart;
      wr(8'h1C, 32'h0000_0001);
      cyc(6);
      chk(32'(nStart - k), 32'h0000_0000);
      convEnabled <= 1'b1;
      $display("TB: trigger done");
      for (int j = 0; j < 16; j++) begin
         k = nRst;
         wr(8'h1D, 32'(j));
         cyc(3);
         chk(32'(nRst - k), 32'(j == 12));
      end
      rdr(8'h21);
      chk(rd, 32'h0000_0000);
      $display("TB: soft reset done");
      finish_test();
   end
endmodule
